// >>> design/swe_evaluator.sv
// Switching output evaluator core
`timescale 1ns/1ps
`default_nettype none
module swe_evaluator
    import swe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // Configuration
    input  wire logic [2:0]        cfg_mode,
    input  wire logic              cfg_nc,
    input  wire logic [1:0]        cfg_hys,
    input  wire logic [DIST_W-1:0] cfg_sp1_wdata,
    input  wire logic              cfg_sp1_we,
    input  wire logic [DIST_W-1:0] cfg_sp2_wdata,
    input  wire logic              cfg_sp2_we,
    input  wire logic [DIST_W-1:0] cfg_band_wdata,
    input  wire logic              cfg_band_we,
    // Readback
    output logic [DIST_W-1:0]      sp1_rdata,
    output logic [DIST_W-1:0]      sp2_rdata,
    output logic [DIST_W-1:0]      band_rdata,
    // Measurement
    input  wire logic              meas_valid,
    input  wire logic              meas_echo,
    input  wire logic [DIST_W-1:0] meas_dist,
    // Switching output
    output logic                   sw_out,
    output logic                   sw_active
);
    // ***********************************************
    // Reset release
    // ***********************************************
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ***********************************************
    // State
    // ***********************************************
    typedef struct packed {
        logic [DIST_W-1:0] sp1;
        logic [DIST_W-1:0] sp2;
        logic [DIST_W-1:0] band;
        logic              act;
    } swe_state_t;

    swe_state_t st_r, st_nxt;

    function automatic logic [DIST_W-1:0] clamp_rng(input logic [DIST_W-1:0] v,
                                                    input logic [DIST_W-1:0] lo,
                                                    input logic [DIST_W-1:0] hi);
        clamp_rng = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [DIST_W-1:0] near_t, far_t, hys_mm, lo_b, hi_b;
    logic [DIST_W+7:0] hys_prod;
    logic [7:0]        hys_pct;
    logic [DIST_W:0]   hi_sum;
    logic              eval;

    always_comb begin
        // Swap so near_t is always the closer threshold
        near_t = (st_r.sp1 > st_r.sp2) ? st_r.sp2 : st_r.sp1;
        far_t  = (st_r.sp1 > st_r.sp2) ? st_r.sp1 : st_r.sp2;
        unique case (cfg_hys)
            SWE_HYS_MED:  hys_pct = HYS_MED_PCT;
            SWE_HYS_HIGH: hys_pct = HYS_HIGH_PCT;
            default:      hys_pct = HYS_LOW_PCT;
        endcase
        hys_prod = meas_dist * hys_pct;
        hys_mm = DIST_W'(hys_prod / PCT_DIV);
        if (hys_mm < HYS_MIN_MM) hys_mm = HYS_MIN_MM;
        // Reflector band from first threshold only
        lo_b   = (st_r.sp1 > st_r.band) ? st_r.sp1 - st_r.band : ADJ_BEG_MM;
        hi_sum = {1'b0, st_r.sp1} + {1'b0, st_r.band};
        hi_b   = hi_sum[DIST_W] ? {DIST_W{1'b1}} : hi_sum[DIST_W-1:0];

        st_nxt = st_r;
        eval   = st_r.act;
        if (cfg_sp1_we) st_nxt.sp1 = clamp_rng(cfg_sp1_wdata, ADJ_BEG_MM, ADJ_END_MM);
        if (cfg_sp2_we) st_nxt.sp2 = clamp_rng(cfg_sp2_wdata, ADJ_BEG_MM, ADJ_END_MM);
        if (cfg_band_we)
            st_nxt.band = clamp_rng(cfg_band_wdata, BAND_MIN_MM, ADJ_END_MM >> 1);
        // Hysteresis holds the threshold and window states near each edge to avoid chatter; reflector mode widens its band while active
        if (meas_valid) begin
            unique case (cfg_mode)
                SWE_MODE_POINT:
                    eval = st_r.act ? (meas_dist <= st_r.sp1 + hys_mm)
                                    : (meas_dist <= st_r.sp1);
                SWE_MODE_WINDOW:
                    eval = st_r.act ? (meas_dist + hys_mm >= near_t && meas_dist <= far_t + hys_mm)
                                    : (meas_dist >= near_t && meas_dist <= far_t);
                SWE_MODE_HYST: begin
                    if (meas_dist <= near_t) eval = 1'b1;
                    else if (meas_dist > far_t) eval = 1'b0;
                end
                SWE_MODE_REFL:
                    eval = !meas_echo || (st_r.act ? !(meas_dist + hys_mm >= lo_b && meas_dist <= hi_b + hys_mm)
                                                   : (meas_dist < lo_b || meas_dist > hi_b));
                default: eval = st_r.act;
            endcase
            // Spare mode codes count as deactivated, so they must hold too
            if (!meas_echo && (cfg_mode == SWE_MODE_POINT || cfg_mode == SWE_MODE_WINDOW
                               || cfg_mode == SWE_MODE_HYST))
                eval = 1'b0;
        end
        st_nxt.act = eval;
    end

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= '{sp1: ADJ_BEG_MM, sp2: ADJ_END_MM, band: BAND_MIN_MM, act: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    assign sp1_rdata  = st_r.sp1;
    assign sp2_rdata  = st_r.sp2;
    assign band_rdata = st_r.band;
    assign sw_active  = st_r.act;
    // Polarity is live even when frozen, giving the manual flip
    assign sw_out     = st_r.act ^ cfg_nc;

    // ***********************************************
    // Checks
    // ***********************************************
    a_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        cfg_mode == SWE_MODE_OFF |=> $stable(sw_active))
        else $error("Active state changed while deactivated");
    a_pol_flip: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        sw_out == (sw_active ^ cfg_nc))
        else $error("Output level does not follow polarity");
    a_no_meas_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        !meas_valid |=> $stable(sw_active))
        else $error("State changed without measurement");
    a_refl_noecho: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        meas_valid && !meas_echo && cfg_mode == SWE_MODE_REFL |=> sw_active)
        else $error("Missing echo did not activate reflector output");
    a_hyst_set: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        meas_valid && meas_echo && cfg_mode == SWE_MODE_HYST && meas_dist <= near_t |=> sw_active)
        else $error("Hysteresis mode did not set at near threshold");
    a_hyst_clr: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        meas_valid && meas_echo && cfg_mode == SWE_MODE_HYST && meas_dist > far_t |=> !sw_active)
        else $error("Hysteresis mode did not clear past far threshold");
    a_win_inside: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        meas_valid && meas_echo && cfg_mode == SWE_MODE_WINDOW
        && meas_dist >= near_t && meas_dist <= far_t |=> sw_active)
        else $error("Window mode inactive inside band");
    a_point_near: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        meas_valid && meas_echo && cfg_mode == SWE_MODE_POINT && meas_dist <= st_r.sp1 |=> sw_active)
        else $error("Threshold mode inactive below first threshold");
    a_band_range: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        band_rdata >= BAND_MIN_MM && band_rdata <= (ADJ_END_MM >> 1))
        else $error("Band half-width out of range");

    // ***********************************************
    // Measurement sequences
    // ***********************************************
    // Reflector measurement with an echo
    sequence s_refl_meas;
        meas_valid && meas_echo && cfg_mode == SWE_MODE_REFL;
    endsequence
    // Threshold measurement with an echo
    sequence s_point_meas;
        meas_valid && meas_echo && cfg_mode == SWE_MODE_POINT;
    endsequence
    // Window measurement with an echo
    sequence s_win_meas;
        meas_valid && meas_echo && cfg_mode == SWE_MODE_WINDOW;
    endsequence
    // Hysteresis measurement between the two thresholds
    sequence s_hyst_hold;
        meas_valid && meas_echo && cfg_mode == SWE_MODE_HYST
        && meas_dist > near_t && meas_dist <= far_t;
    endsequence
    // Lost echo in a mode that clears on it
    sequence s_gap_meas;
        meas_valid && !meas_echo
        && (cfg_mode == SWE_MODE_POINT || cfg_mode == SWE_MODE_WINDOW
            || cfg_mode == SWE_MODE_HYST);
    endsequence

    // ***********************************************
    // Mode checks
    // ***********************************************
    a_refl_short: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_refl_meas ##0 (meas_dist < lo_b) |=> sw_active)
        else $error("Reflector output inactive short of band");
    a_refl_long: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_refl_meas ##0 (meas_dist > hi_b + hys_mm) |=> sw_active)
        else $error("Reflector output inactive beyond band");
    a_refl_band: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_refl_meas ##0 (!sw_active && meas_dist >= lo_b && meas_dist <= hi_b)
        |=> !sw_active)
        else $error("Reflector output active inside band");
    a_point_far: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_point_meas ##0 (meas_dist > st_r.sp1 + hys_mm) |=> !sw_active)
        else $error("Threshold mode active beyond first threshold");
    a_point_hyst: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_point_meas ##0 (sw_active && meas_dist > st_r.sp1
        && meas_dist <= st_r.sp1 + hys_mm) |=> sw_active)
        else $error("Threshold mode released inside hysteresis");
    // Near side only for distances short of the near edge, so the sum cannot wrap
    a_win_outside: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_win_meas ##0 ((meas_dist < near_t && meas_dist + hys_mm < near_t)
        || meas_dist > far_t + hys_mm) |=> !sw_active)
        else $error("Window mode active outside band");
    a_hyst_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_hyst_hold |=> $stable(sw_active))
        else $error("Hysteresis mode changed between thresholds");
    a_gap_clear: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_gap_meas |=> !sw_active)
        else $error("Lost echo did not clear the output");
    a_sp_range: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        sp1_rdata <= ADJ_END_MM && sp2_rdata <= ADJ_END_MM)
        else $error("Threshold outside adjustment range");
endmodule
`default_nettype wire

// >>> design/swe_pkg.sv
// Constants and types for the switching output evaluator
//
// Overview of operation
// - Output mode selects threshold, window, hysteresis, reflector or deactivated.
// - Threshold mode switches at the first threshold, second one ignored.
// - Window mode is active while distance lies between both thresholds.
// - Hysteresis mode sets at first threshold, clears past the second or on a lost echo.
// - Reflector mode activates when distance is short of the reference band.
// - Reflector mode also activates beyond the band or with no echo.
// - Reflector mode uses only the first threshold as reflector distance.
// - Deactivated output stops evaluating and holds its last state.
// - Polarity changes still flip the held output while deactivated.
// - Polarity normally-open or normally-closed decides the output level.
// - Both thresholds are readable, writable millimetre distances within range.
// - Thresholds are swapped internally when the first lies farther away.
// - Band half-width applies both ways, from 1 mm to half range end.
// - Outside hysteresis mode, switching hysteresis is 1, 2 or 5 percent, min 1 mm.
package swe_pkg;
    localparam int DIST_W = 16;
    localparam logic [DIST_W-1:0] ADJ_END_MM = 16'h01f4;
    localparam logic [DIST_W-1:0] ADJ_BEG_MM = 16'h0000;
    localparam logic [DIST_W-1:0] BAND_MIN_MM = 16'h0001;
    localparam logic [DIST_W-1:0] HYS_MIN_MM = 16'h0001;
    localparam logic [7:0] HYS_LOW_PCT = 8'h01;
    localparam logic [7:0] HYS_MED_PCT = 8'h02;
    localparam logic [7:0] HYS_HIGH_PCT = 8'h05;
    localparam logic [7:0] PCT_DIV = 8'h64;

    typedef enum logic [2:0] {
        SWE_MODE_POINT  = 3'b000,
        SWE_MODE_WINDOW = 3'b001,
        SWE_MODE_HYST   = 3'b010,
        SWE_MODE_REFL   = 3'b011,
        SWE_MODE_OFF    = 3'b100
    } swe_mode_t;

    typedef enum logic [1:0] {
        SWE_HYS_LOW  = 2'b00,
        SWE_HYS_MED  = 2'b01,
        SWE_HYS_HIGH = 2'b10
    } swe_hys_t;
endpackage

// >>> dv/swe_plc_input.sv
// Controller input model sampling the switching output
`timescale 1ns/1ps
`default_nettype none
module swe_plc_input (
    // Clock and sampled pin
    input  wire logic clk_sys,
    input  wire logic sw_in,
    // Level seen by the controller
    output logic      seen
);
    logic s1_r;
    // Two stages, since a real input filter lags the pin
    always_ff @(posedge clk_sys) begin
        s1_r <= sw_in;
        seen <= s1_r;
    end
endmodule
`default_nettype wire

// >>> dv/switch_output_evaluator_bench.sv
// Self-checking bench for the switching output evaluator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module switch_output_evaluator_bench;
    import swe_pkg::*;
    logic clk_sys, nrst, cfg_nc, sp1_we, sp2_we, band_we, mv, me, sw_out, sw_active, seen;
    logic [2:0]        cfg_mode;
    logic [1:0]        cfg_hys;
    logic [DIST_W-1:0] wdata, md, sp1_rd, sp2_rd, band_rd;
    int                failures = 0;
    int                tests_run = 0;
    swe_evaluator i_swe_evaluator (.clk_sys(clk_sys), .nrst(nrst), .cfg_mode(cfg_mode),
        .cfg_nc(cfg_nc), .cfg_hys(cfg_hys), .cfg_sp1_wdata(wdata), .cfg_sp1_we(sp1_we),
        .cfg_sp2_wdata(wdata), .cfg_sp2_we(sp2_we), .cfg_band_wdata(wdata),
        .cfg_band_we(band_we), .sp1_rdata(sp1_rd), .sp2_rdata(sp2_rd), .band_rdata(band_rd),
        .meas_valid(mv), .meas_echo(me), .meas_dist(md), .sw_out(sw_out), .sw_active(sw_active));
    swe_plc_input i_swe_plc_input (.clk_sys(clk_sys), .sw_in(sw_out), .seen(seen));
    // ****************************************
    // Drivers, all on the falling edge
    // ****************************************
    task setm(input logic [2:0] m, input logic n, input logic [1:0] h);
        @(negedge clk_sys) {cfg_mode, cfg_nc, cfg_hys} = {m, n, h};
    endtask
    task wr(input logic [2:0] sel, input logic [DIST_W-1:0] v);
        @(negedge clk_sys) {sp1_we, sp2_we, band_we} = sel;
        wdata = v;
        @(negedge clk_sys) {sp1_we, sp2_we, band_we} = 3'h0;
    endtask
    task meas(input logic e, input logic [DIST_W-1:0] d);
        @(negedge clk_sys) {mv, me, md} = {1'b1, e, d};
        @(negedge clk_sys) mv = 1'b0;
    endtask
    task results;
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task t_regs;
        `CHK("sp2 reset", 16'h01f4, sp2_rd)
        `CHK("active reset", 1'b0, sw_active)
        wr(3'b100, 16'h0258);
        `CHK("sp1 clamp", 16'h01f4, sp1_rd)
        wr(3'b001, 16'h0000);
        `CHK("band min", 16'h0001, band_rd)
        wr(3'b001, 16'h012c);
        `CHK("band max", 16'h00fa, band_rd)
    endtask
    task t_point;
        setm(3'h0, 1'b0, 2'h0);
        wr(3'b110, 16'h0064);
        meas(1'b1, 16'h005a);
        `CHK("point near", 1'b1, sw_out)
        meas(1'b1, 16'h0065);
        `CHK("point hys low", 1'b1, sw_active)
        meas(1'b1, 16'h0096);
        `CHK("point far", 1'b0, sw_active)
        setm(3'h0, 1'b0, 2'h2);
        meas(1'b1, 16'h005a);
        meas(1'b1, 16'h0068);
        `CHK("point hys high", 1'b1, sw_active)
        setm(3'h0, 1'b0, 2'h1);
        meas(1'b1, 16'h005a);
        meas(1'b1, 16'h0066);
        `CHK("point hys med", 1'b1, sw_active)
    endtask
    task t_window;
        setm(3'h1, 1'b1, 2'h0);
        wr(3'b100, 16'h012c);
        meas(1'b1, 16'h00c8);
        `CHK("win inside nc", 1'b0, sw_out)
        meas(1'b1, 16'h0032);
        `CHK("win near", 1'b0, sw_active)
        meas(1'b1, 16'h0190);
        `CHK("win far", 1'b0, sw_active)
    endtask
    task t_hyst;
        setm(3'h2, 1'b0, 2'h0);
        wr(3'b100, 16'h0064);
        wr(3'b010, 16'h012c);
        meas(1'b1, 16'h0032);
        meas(1'b1, 16'h00c8);
        `CHK("hyst hold on", 1'b1, sw_active)
        meas(1'b1, 16'h015e);
        meas(1'b1, 16'h00c8);
        `CHK("hyst hold off", 1'b0, sw_active)
    endtask
    task t_refl;
        setm(3'h3, 1'b0, 2'h0);
        wr(3'b100, 16'h00c8);
        wr(3'b011, 16'h000a);
        meas(1'b1, 16'h00c8);
        `CHK("refl in band", 1'b0, sw_active)
        meas(1'b1, 16'h0096);
        `CHK("refl short", 1'b1, sw_active)
        meas(1'b1, 16'h00c8);
        meas(1'b1, 16'h00fa);
        `CHK("refl long", 1'b1, sw_active)
        meas(1'b1, 16'h00c8);
        meas(1'b0, 16'h00c8);
        `CHK("refl no echo", 1'b1, sw_active)
    endtask
    task t_off;
        setm(3'h4, 1'b0, 2'h0);
        meas(1'b1, 16'h00c8);
        `CHK("off hold", 1'b1, sw_out)
        setm(3'h4, 1'b1, 2'h0);
        repeat (3) @(negedge clk_sys);
        `CHK("off flip", 1'b0, seen)
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, cfg_mode, cfg_nc, cfg_hys, sp1_we, sp2_we, band_we, mv, me} = '0;
        {wdata, md} = '0;
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        // Internal reset copy lags by two edges
        repeat (3) @(negedge clk_sys);
        t_regs();
        t_point();
        t_window();
        t_hyst();
        t_refl();
        t_off();
        results();
    end
    initial begin
        #200000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
